// ===== dv/skip_props.sv
// Checker for the skip/test decoder ports.
// Assumes it is bound to the decoder top module.
`timescale 1ns/1ns
module skip_props #(parameter HV_VARIANT = 1) (input wire core_clk, rst, instr_valid, carry_flag, table_read,
  upper_rom_bits_flag, vdet_retention_en, skip_next, squash, ptr_low_we, carry_out, input wire [9:0] instr,
  rom_word, input wire [3:0] mem_word, port_out, pointer_y, input wire [1:0] ptr_low_data);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic m_q, c_q, p_q;
  logic [1:0] r_q;
  wire v = instr_valid && !skip_next;
  wire k = instr_valid && skip_next;
  always @(posedge core_clk) begin
    {m_q, c_q, p_q} <= {!mem_word[instr[1:0]], !carry_flag, pointer_y < 4'h4 && !port_out[pointer_y[1:0]]};
    r_q <= rom_word[9:8];
  end
  property p_up; v && instr == 10'h059 |=> upper_rom_bits_flag; endproperty
  a_up: assert property (p_up) else $error("flag not set");
  property p_tb; table_read && upper_rom_bits_flag |=> ptr_low_we && ptr_low_data == r_q; endproperty
  a_tb: assert property (p_tb) else $error("bad table read");
  property p_vd; v && instr == 10'h293 |=> vdet_retention_en == (HV_VARIANT != 0); endproperty
  a_vd: assert property (p_vd) else $error("bad detector enable");
  property p_mb; v && instr[9:2] == 8'h08 |=> skip_next == m_q; endproperty
  a_mb: assert property (p_mb) else $error("bad bit skip");
  property p_cy; v && instr == 10'h02f |=> skip_next == c_q && carry_out == $past(carry_flag); endproperty
  a_cy: assert property (p_cy) else $error("bad carry skip");
  property p_pd; v && (instr == 10'h024 || instr == 10'h02b) ##1 instr_valid |-> !skip_next ##1 skip_next == p_q; endproperty
  a_pd: assert property (p_pd) else $error("bad port skip");
  property p_sq; k |=> squash && !skip_next; endproperty
  a_sq: assert property (p_sq) else $error("word not squashed");
  property p_ns; !k |=> !squash; endproperty
  a_ns: assert property (p_ns) else $error("stray squash");
  c_sq: cover property (k);
  c_tb: cover property (ptr_low_we);
  c_vd: cover property (vdet_retention_en);
endmodule

// ===== dv/tb.sv
// Self-checking bench for the skip/test decoder.
// Assumes the decoder and its checker are compiled first.
`timescale 1ns/1ns
module tb;
  logic core_clk = 0, rst = 1, instr_valid = 0, carry_flag = 0, table_read = 0;
  logic [9:0] instr = '0, rom_word = '0;
  logic [3:0] mem_word = '0, port_out = '0, pointer_y = '0;
  logic [9:0] ops [9] = '{10'h020, 10'h021, 10'h022, 10'h023, 10'h02f, 10'h024, 10'h02b, 10'h059, 10'h293};
  wire upper_rom_bits_flag, vdet_retention_en, skip_next, squash, ptr_low_we, carry_out;
  wire [1:0] ptr_low_data;
  int n_fail = 0, checks = 0;
  skip_test_instr_decode u_skip_test_instr_decode (.*);
  initial forever #4 core_clk = ~core_clk;
  task chk(input string nm, input logic [9:0] s, e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  function logic sk(input logic [9:0] op);
    if (op[9:2] == 8'h08) return !mem_word[op[1:0]];
    if (op == 10'h02f) return !carry_flag;
    return op[9:4] == 6'h02 && pointer_y < 4'h4 && !port_out[pointer_y[1:0]];
  endfunction
  task run(input logic [9:0] op);
    {mem_word, port_out, pointer_y, carry_flag} = 13'($urandom);
    instr = op;
    instr_valid = 1;
    @(negedge core_clk);
    if (op == 10'h024 || op == 10'h02b) begin
      chk("early skip", skip_next, 0);
      instr = '0;
      @(negedge core_clk);
    end
    chk("skip", skip_next, sk(op));
    instr = '0;
    @(negedge core_clk);
    chk("squash", squash, sk(op));
    instr_valid = 0;
    @(negedge core_clk);
    $display("test %h done", op);
  endtask
  task conclude;
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    void'($urandom(56782));
    repeat (16) @(negedge core_clk);
    rst = 0;
    chk("flag", upper_rom_bits_flag, 0);
    foreach (ops[i]) repeat (6) run(ops[i]);
    rom_word = 10'($urandom);
    table_read = 1;
    @(negedge core_clk);
    chk("ptr", {ptr_low_we, ptr_low_data}, {1'b1, rom_word[9:8]});
    chk("vdet", vdet_retention_en, 1);
    conclude;
  end
endmodule
bind skip_test_instr_decode skip_props #(.HV_VARIANT(HV_VARIANT)) u_skip_props (.*);

// ===== rtl/skip_cond_eval.v
// Evaluates the zero-test for one selected bit of a 4-bit word.
// Assumes the selector is already range-checked by the caller.
`timescale 1ns/1ns
module skip_cond_eval (
  input wire [3:0] word,
  input wire [1:0] sel,
  output wire is_zero
);
  assign is_zero = ~word[sel];
endmodule

// ===== rtl/skip_test_defines.vh
// Opcodes, field positions, pointer limit and reset values for the skip/test decoder.
// Assumes 10-bit instruction words fetched by the surrounding core.
`ifndef SKIP_TEST_DEFINES_VH
`define SKIP_TEST_DEFINES_VH
// ==========================================================================
// Opcodes
`define OP_SET_UPPER_REF 10'h059
`define OP_SET_VDET_EN 10'h293
`define OP_SKIP_MEM_BIT_MASK 10'h3fc
`define OP_SKIP_MEM_BIT 10'h020
`define OP_SKIP_CARRY 10'h02f
`define OP_SKIP_PORT_BIT0 10'h024
`define OP_SKIP_PORT_BIT1 10'h02b
// ==========================================================================
// Fields and sizes
`define BIT_SEL_LSB 0
`define PTR_MAX 4'h3
`define RESET_FLAG 1'b0
`endif

// ===== rtl/skip_test_instr_decode.v
// Decoder and executor for the upper-reference, voltage-detect enable and
// skip-test instructions of a 4-bit core.
// Assumes one instruction word per core_clk, presented with instr_valid.
//
// Behaviour
// - Executing the upper-reference enable instruction sets a flag that makes table reads put ROM bits 9:8 in the pointer low bits.
// - Executing the voltage-detector enable instruction keeps supply-drop detection active during RAM retention.
// - The voltage-detector enable instruction only takes effect on the high-voltage-detect variant.
// - The memory bit-test skips the next instruction when bit j of the data-pointer word is zero.
// - The carry test is one word, one cycle, skips when carry is zero and leaves carry unchanged.
// - The port-bit test is two words, two cycles, and skips when the port bit chosen by pointer 0 to 3 is zero.
`timescale 1ns/1ns
`include "skip_test_defines.vh"
module skip_test_instr_decode #(
  parameter HV_VARIANT = 1
) (
  input wire core_clk,
  input wire rst,
  input wire instr_valid,
  input wire [9:0] instr,
  input wire [3:0] mem_word,
  input wire carry_flag,
  input wire [3:0] port_out,
  input wire [3:0] pointer_y,
  input wire table_read,
  input wire [9:0] rom_word,
  output reg upper_rom_bits_flag,
  output reg vdet_retention_en,
  output reg skip_next,
  output reg squash,
  output reg ptr_low_we,
  output reg [1:0] ptr_low_data,
  output reg carry_out
);
  // ========================================================================
  // Decode helpers
  function is_mem_bit_test;
    input [9:0] op;
    begin
      is_mem_bit_test = (op & `OP_SKIP_MEM_BIT_MASK) == `OP_SKIP_MEM_BIT;
    end
  endfunction

  wire mem_bit_zero;
  wire port_bit_zero;
  skip_cond_eval u_mem (
    .word(mem_word),
    .sel(instr[1:0]),
    .is_zero(mem_bit_zero)
  );
  skip_cond_eval u_port (
    .word(port_out),
    .sel(pointer_y[1:0]),
    .is_zero(port_bit_zero)
  );

  // ========================================================================
  // Execution state
  reg squash_pend_q;
  reg port_second_q;
  reg port_zero_q;
  // The second word of an executed port-bit test is an operand, so it is never decoded as an instruction.
  wire executing = instr_valid & ~squash_pend_q & ~port_second_q;
  reg skip_d;

  always @* begin
    skip_d = 1'b0;
    if (executing) begin
      if (is_mem_bit_test(instr)) begin
        skip_d = mem_bit_zero;
      end else if (instr == `OP_SKIP_CARRY) begin
        skip_d = ~carry_flag;
      end
    end
    if (instr_valid & port_second_q) begin
      skip_d = port_zero_q;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      upper_rom_bits_flag <= `RESET_FLAG;
      vdet_retention_en <= `RESET_FLAG;
      skip_next <= 1'b0;
      squash <= 1'b0;
      squash_pend_q <= 1'b0;
      port_second_q <= 1'b0;
      port_zero_q <= 1'b0;
      ptr_low_we <= 1'b0;
      ptr_low_data <= 2'h0;
      carry_out <= 1'b0;
    end else begin
      carry_out <= carry_flag;
      skip_next <= skip_d;
      // A squashed word still spends its cycle; only its effects are dropped.
      squash <= instr_valid & squash_pend_q;
      if (instr_valid) begin
        squash_pend_q <= skip_d;
      end
      if (instr_valid & port_second_q) begin
        port_second_q <= 1'b0;
      end else if (executing & ((instr == `OP_SKIP_PORT_BIT0) | (instr == `OP_SKIP_PORT_BIT1))) begin
        // Pointer values above 3 are undefined; they never skip here.
        port_second_q <= 1'b1;
        port_zero_q <= port_bit_zero & (pointer_y <= `PTR_MAX);
      end
      if (executing & (instr == `OP_SET_UPPER_REF)) begin
        upper_rom_bits_flag <= 1'b1;
      end
      if (executing & (instr == `OP_SET_VDET_EN) & (HV_VARIANT != 0)) begin
        vdet_retention_en <= 1'b1;
      end
      ptr_low_we <= table_read & upper_rom_bits_flag;
      ptr_low_data <= rom_word[9:8];
    end
  end
endmodule
